//--- hdl/vic_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

module vic_edge_detect
    import vic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    vic_edge_if.det  port
);

    logic prev_r;
    logic armed_r;
    logic rise;
    logic fall;

    // Armed flag stops a false rise after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r  <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            prev_r  <= port.pin;
            armed_r <= 1'b1;
        end
    end

    assign rise     = armed_r & port.pin & ~prev_r;
    assign fall     = armed_r & ~port.pin & prev_r;
    assign port.hit = (rise & port.rise_en) | (fall & port.fall_en); // see (R05)

endmodule

`default_nettype wire

//--- hdl/vic_edge_if.sv
`timescale 1ns/1ps
`default_nettype none

interface vic_edge_if;
    logic pin;
    logic rise_en;
    logic fall_en;
    logic hit;

    modport det (
        input  pin,
        input  rise_en,
        input  fall_en,
        output hit
    );

    modport ctl (
        output pin,
        output rise_en,
        output fall_en,
        input  hit
    );
endinterface

`default_nettype wire

//--- hdl/vic_pkg.sv
package vic_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned SRC_W    = 10;
    localparam int unsigned MSK_W    = 9;
    localparam int unsigned ID_W     = 4;
    localparam int unsigned VEC_W    = 16;
    localparam int unsigned NUM_PINS = 3;
    localparam int unsigned EDGE_FLD = 2;
    localparam int unsigned EDGE_W   = 6;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_REQ    = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_BLOCK  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_EDGE   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_IRQEN  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_ACTIVE = 8'h14;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [SRC_W-1:0]  RST_REQ   = 10'h000;
    localparam logic [MSK_W-1:0]  RST_BLOCK = 9'h1ff;
    localparam logic [EDGE_W-1:0] RST_EDGE  = 6'h00;
    localparam logic [SRC_W-1:0]  RST_IRQEN = 10'h000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned EDGE_RISE_BIT = 0;
    localparam int unsigned EDGE_FALL_BIT = 1;
    localparam int unsigned CTRL_IE_BIT   = 0;
    localparam int unsigned CTRL_WDT_BIT  = 1;
    localparam int unsigned CTRL_NMI_IN_SERVICE_BIT = 2;
    localparam int unsigned ACT_VEC_LSB   = 0;
    localparam int unsigned ACT_ID_LSB    = 16;
    localparam int unsigned ACT_REQ_BIT   = 20;

    // ------------------------------------------------------------
    // Source numbering: 0 is the non-maskable one, 1 + level otherwise
    // ------------------------------------------------------------
    localparam int unsigned SRC_NMI    = 0;
    localparam int unsigned SRC_WDT_IV = 1;
    localparam int unsigned SRC_PIN_A  = 2;
    localparam int unsigned SRC_SERIAL = 5;
    localparam int unsigned SRC_TX     = 6;
    localparam int unsigned SRC_TMR8   = 7;
    localparam int unsigned SRC_TMR16  = 8;
    localparam int unsigned SRC_CONV   = 9;

    localparam logic [ID_W-1:0] ID_NMI  = 4'h0;
    localparam logic [ID_W-1:0] ID_BASE = 4'h1;

    // Vector table addresses, indexed by source number
    localparam logic [VEC_W-1:0] VEC_TABLE [SRC_W] = '{
        16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c,
        16'h000e, 16'h0010, 16'h0012, 16'h0014, 16'h0016
    };

endpackage

//--- hdl/vic_top.sv
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Operation
// (R01) Ten sources are handled, one non-maskable and nine maskable.
// (R02) In watchdog mode the watchdog overflow raises the non-maskable request with vector 0004H.
// (R03) In interval mode the watchdog overflow raises the maskable request of level 0.
// (R04) Of the maskable requests pending together the lowest level number wins, 0 highest and 8 lowest.
// (R05) Each external pin detects a selectable edge: rising, falling or both.
// (R06) The three pin detections form maskable requests at levels 1, 2 and 3.
// (R07) Serial receive end and three-wire transfer end share one request at level 4.
// (R08) Serial transmit end raises a request at level 5.
// (R09) The 8-bit timer compare match raises a request at level 6.
// (R10) The 16-bit timer compare match raises a request at level 7.
// (R11) Conversion completion raises a request at level 8, the lowest.
// (R12) Each source latches its event in its own request flag and each maskable one has a block flag.
// (R13) A global allow flag admits or holds back maskable requests.
// (R14) A flag shows that non-maskable servicing is in progress.
// (R15) A maskable request reaches the CPU only if flagged, unblocked and globally allowed; the non-maskable one bypasses both.
// (R16) A source's request flag is cleared when the CPU acknowledges it and takes its vector.

module vic_top
    import vic_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic                   pready,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pslverr,
    input  wire logic              watchdog_overflow_irq,
    input  wire logic              ext_pin_irq_a,
    input  wire logic              ext_pin_irq_b,
    input  wire logic              ext_pin_irq_c,
    input  wire logic              async_rx_done_irq,
    input  wire logic              sync_xfer_done_irq,
    input  wire logic              async_tx_done_irq,
    input  wire logic              timer8_match_irq,
    input  wire logic              timer16_match_irq,
    input  wire logic              conversion_done_irq,
    input  wire logic              cpu_irq_ack,
    input  wire logic              cpu_nmi_return,
    output logic                   irq,
    output logic                   cpu_irq_req,
    output logic                   cpu_irq_nmi,
    output logic      [VEC_W-1:0]  cpu_irq_vector
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [SRC_W-1:0]  req_r;
    logic [SRC_W-1:0]  req_nxt;
    logic [MSK_W-1:0]  source_block_flag_r;
    logic [EDGE_W-1:0] edge_sel_r;
    logic [SRC_W-1:0]  irq_en_r;
    logic              global_irq_allow_r;
    logic              global_irq_allow_nxt;
    logic              wdt_interval_r;
    logic              nmi_in_service_r;
    logic              nmi_in_service_nxt;
    logic [ID_W-1:0]   src_id_r;
    logic [ID_W-1:0]   src_id_nxt;
    logic              cpu_irq_req_nxt;
    logic              cpu_irq_nmi_nxt;
    logic              irq_nxt;
    logic              pready_nxt;
    logic              pslverr_nxt;
    logic [DATA_W-1:0] prdata_nxt;

    // ------------------------------------------------------------
    // External pin edge detection
    // ------------------------------------------------------------
    vic_edge_if       eif [NUM_PINS] ();
    logic [NUM_PINS-1:0] pin_in;
    logic [NUM_PINS-1:0] pin_hit;

    assign pin_in = {ext_pin_irq_c, ext_pin_irq_b, ext_pin_irq_a};

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        assign eif[i].pin     = pin_in[i];
        assign eif[i].rise_en = edge_sel_r[i*EDGE_FLD + EDGE_RISE_BIT]; // see (R05)
        assign eif[i].fall_en = edge_sel_r[i*EDGE_FLD + EDGE_FALL_BIT]; // see (R05)
        assign pin_hit[i]     = eif[i].hit;

        vic_edge_detect u_det (
            .pclk    (pclk),
            .presetn (presetn),
            .port    (eif[i].det)
        );
    end

    // ------------------------------------------------------------
    // Event routing onto request flags
    // ------------------------------------------------------------
    logic [SRC_W-1:0] ev; // see (R01)

    assign ev[SRC_NMI]    = watchdog_overflow_irq & ~wdt_interval_r;   // see (R02)
    assign ev[SRC_WDT_IV] = watchdog_overflow_irq & wdt_interval_r;    // see (R03)
    assign ev[SRC_PIN_A +: NUM_PINS] = pin_hit;                        // see (R06)
    assign ev[SRC_SERIAL] = async_rx_done_irq | sync_xfer_done_irq;    // see (R07)
    assign ev[SRC_TX]     = async_tx_done_irq;                         // see (R08)
    assign ev[SRC_TMR8]   = timer8_match_irq;                          // see (R09)
    assign ev[SRC_TMR16]  = timer16_match_irq;                         // see (R10)
    assign ev[SRC_CONV]   = conversion_done_irq;                       // see (R11)

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic access;
    logic wr_fire;
    logic sel_req;
    logic sel_block;
    logic sel_edge;
    logic sel_ctrl;
    logic sel_irqen;
    logic sel_active;
    logic addr_hit;

    // One wait state so that the answer comes from flip-flops
    assign access     = psel & penable;
    assign wr_fire    = access & pready & pwrite & ~pslverr;
    assign sel_req    = paddr == OFF_REQ;
    assign sel_block  = paddr == OFF_BLOCK;
    assign sel_edge   = paddr == OFF_EDGE;
    assign sel_ctrl   = paddr == OFF_CTRL;
    assign sel_irqen  = paddr == OFF_IRQEN;
    assign sel_active = paddr == OFF_ACTIVE;
    assign addr_hit   = sel_req | sel_block | sel_edge | sel_ctrl | sel_irqen | sel_active;

    assign pready_nxt  = access & ~pready;
    assign pslverr_nxt = pready_nxt & ~addr_hit;

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    logic [MSK_W-1:0] pend_m;
    logic             any_m;
    logic             nmi_pend;
    logic [ID_W-1:0]  win_lvl;
    logic             ack_fire;
    logic             ack_nmi;
    logic             ack_mask;
    logic [SRC_W-1:0] ack_clr;
    logic [SRC_W-1:0] w1c;

    assign pend_m   = req_r[SRC_W-1:1] & ~source_block_flag_r;      // see (R12)
    assign any_m    = |pend_m;
    // A second watchdog NMI waits until the first is serviced
    assign nmi_pend = req_r[SRC_NMI] & ~nmi_in_service_r;

    // Lowest level number wins
    always_comb begin
        win_lvl = '0;
        for (int k = MSK_W - 1; k >= 0; k--) begin
            if (pend_m[k]) begin
                win_lvl = ID_W'(k);                                  // see (R04)
            end
        end
    end

    assign src_id_nxt = nmi_pend ? ID_NMI : win_lvl + ID_BASE;

    // Request drops for one cycle after an ack so the next pick
    // sees the flag that was just cleared
    assign cpu_irq_req_nxt = ~ack_fire & (nmi_pend | (global_irq_allow_r & any_m)); // see (R15)
    assign cpu_irq_nmi_nxt = ~ack_fire & nmi_pend;                  // see (R15)

    assign ack_fire = cpu_irq_ack & cpu_irq_req;
    assign ack_nmi  = ack_fire & cpu_irq_nmi;
    assign ack_mask = ack_fire & ~cpu_irq_nmi;
    assign ack_clr  = ack_fire ? (SRC_W'(1) << src_id_r) : '0;      // see (R16)

    // ------------------------------------------------------------
    // Flag updates; a new event beats a clear in the same cycle
    // ------------------------------------------------------------
    assign w1c     = (wr_fire & sel_req) ? pwdata[SRC_W-1:0] : '0;
    assign req_nxt = (req_r & ~w1c & ~ack_clr) | ev;                // see (R12)

    assign nmi_in_service_nxt = ack_nmi | (nmi_in_service_r & ~cpu_nmi_return); // see (R14)

    // Software write of the allow bit takes precedence over the ack
    assign global_irq_allow_nxt = (wr_fire & sel_ctrl) ? pwdata[CTRL_IE_BIT]
                                : (ack_mask ? 1'b0 : global_irq_allow_r); // see (R13)

    assign irq_nxt = |(req_nxt & irq_en_r);

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_data;

    always_comb begin
        rd_data = '0;
        if (sel_req) begin
            rd_data[SRC_W-1:0] = req_r;
        end
        if (sel_block) begin
            rd_data[MSK_W-1:0] = source_block_flag_r;
        end
        if (sel_edge) begin
            rd_data[EDGE_W-1:0] = edge_sel_r;
        end
        if (sel_ctrl) begin
            rd_data[CTRL_IE_BIT]   = global_irq_allow_r;
            rd_data[CTRL_WDT_BIT]  = wdt_interval_r;
            rd_data[CTRL_NMI_IN_SERVICE_BIT] = nmi_in_service_r;
        end
        if (sel_irqen) begin
            rd_data[SRC_W-1:0] = irq_en_r;
        end
        if (sel_active) begin
            rd_data[ACT_VEC_LSB +: VEC_W] = cpu_irq_vector;
            rd_data[ACT_ID_LSB +: ID_W]   = src_id_r;
            rd_data[ACT_REQ_BIT]          = cpu_irq_req;
        end
    end

    assign prdata_nxt = (pready_nxt & ~pwrite) ? rd_data : '0;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
            prdata  <= prdata_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_r              <= RST_REQ;
            global_irq_allow_r <= 1'b0;
            nmi_in_service_r   <= 1'b0;
            irq                <= 1'b0;
        end else begin
            req_r              <= req_nxt;
            global_irq_allow_r <= global_irq_allow_nxt;
            nmi_in_service_r   <= nmi_in_service_nxt;
            irq                <= irq_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_block_flag_r <= RST_BLOCK;
        end else if (wr_fire && sel_block) begin
            source_block_flag_r <= pwdata[MSK_W-1:0];               // see (R12)
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_sel_r <= RST_EDGE;
        end else if (wr_fire && sel_edge) begin
            edge_sel_r <= pwdata[EDGE_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_interval_r <= 1'b0;
        end else if (wr_fire && sel_ctrl) begin
            wdt_interval_r <= pwdata[CTRL_WDT_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_r <= RST_IRQEN;
        end else if (wr_fire && sel_irqen) begin
            irq_en_r <= pwdata[SRC_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_irq_req    <= 1'b0;
            cpu_irq_nmi    <= 1'b0;
            src_id_r       <= ID_NMI;
            cpu_irq_vector <= VEC_TABLE[SRC_NMI];
        end else begin
            cpu_irq_req    <= cpu_irq_req_nxt;
            cpu_irq_nmi    <= cpu_irq_nmi_nxt;
            src_id_r       <= src_id_nxt;
            cpu_irq_vector <= VEC_TABLE[src_id_nxt];                 // see (R02)
        end
    end

endmodule

`default_nettype wire

//--- test/vic_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module vic_cpu_model
    import vic_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             run,
    input  wire logic [3:0]       ack_wait,
    input  wire logic             cpu_irq_req,
    input  wire logic             cpu_irq_nmi,
    input  wire logic [VEC_W-1:0] cpu_irq_vector,
    output logic                  cpu_irq_ack,
    output logic                  cpu_nmi_return,
    output logic      [VEC_W-1:0] taken_vec,
    output logic      [7:0]       taken_cnt
);
    logic [3:0] wait_r;
    logic [3:0] svc_r;

    // Vector taken at the ack edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r         <= '0;
            svc_r          <= '0;
            cpu_irq_ack    <= 1'b0;
            cpu_nmi_return <= 1'b0;
            taken_vec      <= '0;
            taken_cnt      <= '0;
        end else begin
            cpu_irq_ack    <= 1'b0;
            cpu_nmi_return <= (svc_r == 4'h1);
            wait_r         <= '0;
            if (svc_r != 4'h0)
                svc_r <= svc_r - 4'h1;
            if (cpu_irq_ack && cpu_irq_req) begin
                taken_vec <= cpu_irq_vector;
                taken_cnt <= taken_cnt + 8'h1;
                if (cpu_irq_nmi)
                    svc_r <= 4'hf;
            end else if (run && cpu_irq_req && !cpu_irq_ack) begin
                if (wait_r >= ack_wait)
                    cpu_irq_ack <= 1'b1;
                else
                    wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule

`default_nettype wire

//--- test/vic_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

module vic_top_bench
    import vic_pkg::*;
;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic              pready, pslverr, irq, req, nmi, ack, nret, rerr;
    logic              run = 1'b0;
    logic [DATA_W-1:0] prdata, rdata;
    logic [VEC_W-1:0]  vec, taken_vec;
    logic [7:0]        taken_cnt, n0, n_start;
    logic [6:0]        ev = '0;
    logic [2:0]        pin = '0;
    logic [3:0]        ack_wait = 4'h2;
    logic [8:0]        pat, blk;
    logic [31:0]       seed = 32'h1f30;
    int                err_total = 0;
    int                samples_checked = 0;
    int                cycles = 0;
    logic [31:0]       rst_exp [6] = '{32'h0, 32'h1ff, 32'h0, 32'h0, 32'h0, 32'h10006};

    vic_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .watchdog_overflow_irq(ev[0]), .async_rx_done_irq(ev[1]), .sync_xfer_done_irq(ev[2]),
        .async_tx_done_irq(ev[3]), .timer8_match_irq(ev[4]), .timer16_match_irq(ev[5]),
        .conversion_done_irq(ev[6]), .ext_pin_irq_a(pin[0]), .ext_pin_irq_b(pin[1]),
        .ext_pin_irq_c(pin[2]), .cpu_irq_ack(ack), .cpu_nmi_return(nret), .irq(irq),
        .cpu_irq_req(req), .cpu_irq_nmi(nmi), .cpu_irq_vector(vec)
    );
    vic_cpu_model cpu (
        .pclk(pclk), .presetn(presetn), .run(run), .ack_wait(ack_wait), .cpu_irq_req(req),
        .cpu_irq_nmi(nmi), .cpu_irq_vector(vec), .cpu_irq_ack(ack), .cpu_nmi_return(nret),
        .taken_vec(taken_vec), .taken_cnt(taken_cnt)
    );

    always #2.5 pclk = ~pclk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [31:0] exp_vec(input int l);
        return 32'h0006 + 32'(2 * l);
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Idle cycle after release
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, '0);
        chk(nm, rdata, e);
    endtask

    // Bit k of s sets flag k; bits 0 and 1 both pulse the watchdog, so the CTRL mode bit picks flag 0 or 1
    task automatic fire(input logic [9:0] s, input logic alt);
        ev  <= {s[9:6], s[5] & alt, s[5] & ~alt, s[1] | s[0]};
        pin <= s[4:2];
        @(posedge pclk);
        ev <= '0;
        @(posedge pclk);
        pin <= '0;
        @(posedge pclk);
    endtask

    task automatic wait_taken(input logic [7:0] n_before);
        int n;
        n = 0;
        while (taken_cnt === n_before && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk("taken", 32'(taken_cnt), 32'(n_before + 8'h1));
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge pclk);
        chk("irq", {31'h0, irq}, {31'h0, e});
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++)
            rd(8'(4 * i), rst_exp[i], "reset_value");
        apb(1'b0, 8'h18, '0);
        chk("unmapped_err", {31'h0, rerr}, 32'h1);
        apb(1'b1, OFF_CTRL, 32'h4);
        rd(OFF_CTRL, 32'h0, "nmi_flag_ro");
        $display("test registers done");
        apb(1'b1, OFF_EDGE, 32'h15);
        for (int k = 0; k < 10; k++) begin
            apb(1'b1, OFF_CTRL, (k == 1) ? 32'h2 : 32'h0);
            fire(10'h1 << k, k[0]);
            rd(OFF_REQ, 32'h1 << k, "req_flag");
            apb(1'b1, OFF_REQ, 32'h1 << k);
            rd(OFF_REQ, 32'h0, "req_clear");
        end
        $display("test sources done");
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, OFF_EDGE, 32'(m));
            pin <= 3'b001;
            repeat (2) @(posedge pclk);
            rd(OFF_REQ, m[0] ? 32'h4 : 32'h0, "rise_edge");
            apb(1'b1, OFF_REQ, 32'h4);
            pin <= 3'b000;
            repeat (2) @(posedge pclk);
            rd(OFF_REQ, m[1] ? 32'h4 : 32'h0, "fall_edge");
            apb(1'b1, OFF_REQ, 32'h4);
        end
        $display("test edges done");
        apb(1'b1, OFF_IRQEN, 32'h80);
        fire(10'h080, 1'b0);
        irq_is(1'b1);
        apb(1'b1, OFF_IRQEN, 32'h0);
        irq_is(1'b0);
        apb(1'b1, OFF_IRQEN, 32'h80);
        irq_is(1'b1);
        apb(1'b1, OFF_REQ, 32'h80);
        irq_is(1'b0);
        $display("test irq done");
        run <= 1'b1;
        n0 = taken_cnt;
        fire(10'h001, 1'b0);
        wait_taken(n0);
        chk("nmi_vec", 32'(taken_vec), 32'h0004);
        rd(OFF_CTRL, 32'h4, "nmi_busy");
        rd(OFF_REQ, 32'h0, "nmi_flag_gone");
        repeat (20) @(posedge pclk);
        rd(OFF_CTRL, 32'h0, "nmi_done");
        $display("test nmi done");
        // Round 0 fires every level
        apb(1'b1, OFF_EDGE, 32'h15);
        for (int r = 0; r < 5; r++) begin
            seed = xs(seed);
            pat = (r == 0) ? 9'h1ff : seed[8:0];
            blk = (r == 0) ? 9'h000 : seed[17:9] & seed[26:18];
            ack_wait <= 4'(seed[30:28]);
            apb(1'b1, OFF_BLOCK, 32'(blk));
            rd(OFF_BLOCK, 32'(blk), "block_rw");
            apb(1'b1, OFF_CTRL, 32'h2);
            n_start = taken_cnt;
            fire({pat, 1'b0}, seed[31]);
            rd(OFF_REQ, 32'({pat, 1'b0}), "pending");
            chk("allow_off", 32'(taken_cnt), 32'(n_start));
            for (int l = 0; l < 9; l++) begin
                if (pat[l] && !blk[l]) begin
                    n0 = taken_cnt;
                    apb(1'b1, OFF_CTRL, 32'h3);
                    wait_taken(n0);
                    chk("order", 32'(taken_vec), exp_vec(l));
                end
            end
            repeat (6) @(posedge pclk);
            chk("total", 32'(taken_cnt), 32'(n_start + 8'($countones(pat & ~blk))));
            rd(OFF_REQ, 32'({pat & blk, 1'b0}), "blocked_kept");
            apb(1'b1, OFF_REQ, 32'h3ff);
        end
        $display("test priority done");
        final_report();
    end
endmodule

`default_nettype wire

//--- test/vic_top_properties.sv
`timescale 1ns/1ps
`default_nettype none

module vic_top_properties
    import vic_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic              pready,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pslverr,
    input wire logic              cpu_irq_ack,
    input wire logic              cpu_nmi_return,
    input wire logic              cpu_irq_req,
    input wire logic              cpu_irq_nmi,
    input wire logic [VEC_W-1:0]  cpu_irq_vector
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // Shadow of the allow and in-service flags
    // ----------------------------------------
    wire ctrl_wr  = psel && penable && pready && pwrite && paddr == OFF_CTRL;
    wire ack_take = cpu_irq_ack && cpu_irq_req;
    wire mapped   = paddr inside {OFF_REQ, OFF_BLOCK, OFF_EDGE, OFF_CTRL, OFF_IRQEN, OFF_ACTIVE};
    logic allow_r;
    logic nmi_busy_r;

    // Write beats the ack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            allow_r    <= 1'b0;
            nmi_busy_r <= 1'b0;
        end else begin
            if (ctrl_wr)
                allow_r <= pwdata[CTRL_IE_BIT];
            else if (ack_take && !cpu_irq_nmi)
                allow_r <= 1'b0;
            if (ack_take && cpu_irq_nmi)
                nmi_busy_r <= 1'b1;
            else if (cpu_nmi_return)
                nmi_busy_r <= 1'b0;
        end
    end

    AST_APB_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready timing");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready too long");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == '0)
        else $error("prdata not idle");
    AST_ERR_MAP: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong");
    AST_NMI_VECTOR: assert property (cpu_irq_req && cpu_irq_nmi |-> cpu_irq_vector == 16'h0004)
        else $error("nmi vector");
    AST_LEVEL_VECTOR: assert property (cpu_irq_req && !cpu_irq_nmi |->
        cpu_irq_vector inside {[16'h0006:16'h0016]} && !cpu_irq_vector[0])
        else $error("level vector");
    AST_ACK_DROP: assert property (ack_take |=> !cpu_irq_req)
        else $error("req after ack");
    AST_NMI_IN_REQ: assert property (cpu_irq_nmi |-> cpu_irq_req)
        else $error("nmi without req");
    AST_NMI_HELD: assert property (nmi_busy_r |-> !cpu_irq_nmi)
        else $error("nmi in service");
    AST_ALLOW_GATE: assert property (!allow_r && !$past(allow_r) && cpu_irq_req |-> cpu_irq_nmi)
        else $error("req not allowed");
endmodule

bind vic_top vic_top_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cpu_irq_ack(cpu_irq_ack), .cpu_nmi_return(cpu_nmi_return), .cpu_irq_req(cpu_irq_req),
    .cpu_irq_nmi(cpu_irq_nmi), .cpu_irq_vector(cpu_irq_vector)
);

`default_nettype wire
